// ===== deac_pkg.sv
// Constants for the data nonvolatile memory access controller.
// Assumes a CPU core reaching the registers by a special-function port.
//
// Summary of operation
// - 256 bytes, 8-bit address 00h to FFh, one byte per access.
// - A byte write erases then programs; a timer sets its length.
// - The unlock port stores nothing and reads as zero.
// - Bit 7 selects flash when 1, data memory when 0.
// - Bit 6 set selects configuration space over bit 7 for writes; reads ignore bit 6.
// - Gate bit 2 clear blocks writes and refuses setting write-start.
// - Clearing the gate does not abort a running cycle.
// - Error bit 3 set when a master-clear or watchdog reset cuts short a write.
// - On write error, select and row-erase bits are kept.
// - A reset during a write clears data and address registers.
// - Write-start bit 1 is set-only; hardware clears it at the end.
// - Read-start bit 0 is set-only; cleared after a one-cycle read.
// - Read-start is ignored while memory select is 1.
// - Read data is in the data register the next cycle.
// - Data register holds until another read, a firmware write or a reset.
// - Row-erase bit 4 makes the next write a timed cycle with no array write; cleared at end.
// - Write completion sets the completion flag; firmware clears it.
// - Write starts only after 55h, AAh to the unlock port, then start.
// - Control, address and data are locked during a write.
// - Write-start cannot be set in the same write that sets the gate.
// - Power-up clears the write-enable gate.

package deac_pkg;

  // ==========================================================
  // Register select codes
  localparam logic [1:0] DEAC_SEL_CONTROL = 2'h0;
  localparam logic [1:0] DEAC_SEL_UNLOCK  = 2'h1;
  localparam logic [1:0] DEAC_SEL_DATA    = 2'h2;
  localparam logic [1:0] DEAC_SEL_ADDRESS = 2'h3;

  // ==========================================================
  // Control register fields
  localparam int DEAC_BIT_READ     = 0;
  localparam int DEAC_BIT_WRITE    = 1;
  localparam int DEAC_BIT_GATE     = 2;
  localparam int DEAC_BIT_ERROR    = 3;
  localparam int DEAC_BIT_ROW      = 4;
  localparam int DEAC_BIT_CONFIG   = 6;
  localparam int DEAC_BIT_MEMSEL   = 7;

  // ==========================================================
  // Unlock keys and reset values
  localparam logic [7:0] DEAC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] DEAC_KEY_SECOND = 8'hAA;
  localparam logic [7:0] DEAC_RESET_BYTE = 8'h00;

  // ==========================================================
  // Timing: write time in ns, counted at 50 MHz
  localparam int DEAC_CLOCK_MHZ      = 50;
  localparam int DEAC_WRITE_TIME_NS  = 4000;
  localparam int DEAC_WRITE_CYCLES   =
    (DEAC_WRITE_TIME_NS * DEAC_CLOCK_MHZ) / 1000;

  typedef enum logic [1:0] {
    DEAC_UNLOCK_IDLE  = 2'b00,
    DEAC_UNLOCK_FIRST = 2'b01,
    DEAC_UNLOCK_ARMED = 2'b10
  } deac_unlock_e;

endpackage : deac_pkg

// ===== deac_memory.sv
// Byte storage array of the data nonvolatile memory, flip-flop based.
// Assumes the controller gives one-cycle write pulses.
`timescale 1ns/1ps

module deac_memory #(
  parameter int DEPTH = 256
) (
  input  wire logic       clock,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       wr_pulse,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data
);
  import deac_pkg::*;

  logic [7:0] cells [DEPTH];
  logic [7:0] next_cells [DEPTH];

  // Contents survive reset, as a nonvolatile array should
  always_comb begin
    next_cells = cells;
    if (wr_pulse) begin
      next_cells[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    cells <= next_cells;
  end

  assign rd_data = cells[rd_addr];

endmodule : deac_memory

// ===== deac_timer.sv
// Self-timed write cycle counter.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps

module deac_timer #(
  parameter int CYCLES = 200
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  import deac_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_busy;
  logic          next_done;

  always_comb begin
    next_count = count;
    next_busy  = busy;
    next_done  = 1'b0;
    if (busy) begin
      if (count == LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end else if (start) begin
      next_busy  = 1'b1;
      next_count = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      busy  <= next_busy;
      done  <= next_done;
    end
  end

endmodule : deac_timer

// ===== deac_controller.sv
// Access controller for the data nonvolatile memory: control, unlock,
// data and address registers over the CPU special-function port.
// Assumes single-cycle register strobes synchronous to clock.
`timescale 1ns/1ps

module deac_controller #(
  parameter int WRITE_CYCLES = deac_pkg::DEAC_WRITE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       power_on_reset,
  input  wire logic       master_clear_reset,
  input  wire logic       watchdog_timer_reset,
  input  wire logic [1:0] reg_select,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       write_complete_clear,
  output logic            write_complete_flag,
  output logic            write_busy
);
  import deac_pkg::*;

  // ==========================================================
  // State
  logic [7:0]   nvm_address;
  logic [7:0]   nvm_data;
  logic         memory_select;
  logic         configuration_select;
  logic         row_erase;
  logic         write_error_flag;
  logic         write_enable_gate;
  logic         write_start;
  logic         read_start;
  deac_unlock_e unlock;

  logic [7:0]   next_nvm_address;
  logic [7:0]   next_nvm_data;
  logic         next_memory_select;
  logic         next_configuration_select;
  logic         next_row_erase;
  logic         next_write_error_flag;
  logic         next_write_enable_gate;
  logic         next_write_start;
  logic         next_read_start;
  deac_unlock_e next_unlock;
  logic         next_write_complete_flag;
  logic [7:0]   next_reg_rdata;

  logic [7:0]   mem_rdata;
  logic         timer_busy;
  logic         timer_done;
  logic         launch;
  logic         mem_write;
  logic         ext_reset;
  logic         data_target;

  // A data-space write without row erase goes to the array; flash and configuration
  // cycles are timed but have no storage here
  assign data_target = !configuration_select && !memory_select;
  assign mem_write   = timer_done && data_target && !row_erase;
  assign ext_reset   = master_clear_reset || watchdog_timer_reset;

  function automatic logic [7:0] control_view(
    input logic ms, input logic cs, input logic re, input logic er,
    input logic ge, input logic ws, input logic rs);
    control_view = {ms, cs, 1'b0, re, er, ge, ws, rs};
  endfunction : control_view

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_nvm_address          = nvm_address;
    next_nvm_data             = nvm_data;
    next_memory_select        = memory_select;
    next_configuration_select = configuration_select;
    next_row_erase            = row_erase;
    next_write_error_flag     = write_error_flag;
    next_write_enable_gate    = write_enable_gate;
    next_write_start          = write_start;
    next_read_start           = 1'b0;
    next_unlock               = unlock;
    next_write_complete_flag  = write_complete_flag;
    launch                    = 1'b0;

    // Read completes in one cycle; data lands the next cycle
    if (read_start) begin
      next_nvm_data = mem_rdata;
    end

    if (reg_write && !write_start) begin
      if (reg_select == DEAC_SEL_UNLOCK) begin
        // Unlock key sequence; any other value resets it
        if (reg_wdata == DEAC_KEY_FIRST) begin
          next_unlock = DEAC_UNLOCK_FIRST;
        end else if (reg_wdata == DEAC_KEY_SECOND &&
                     unlock == DEAC_UNLOCK_FIRST) begin
          next_unlock = DEAC_UNLOCK_ARMED;
        end else begin
          next_unlock = DEAC_UNLOCK_IDLE;
        end
      end else begin
        next_unlock = DEAC_UNLOCK_IDLE;
      end
      if (reg_select == DEAC_SEL_ADDRESS) begin
        next_nvm_address = reg_wdata;
      end else if (reg_select == DEAC_SEL_DATA) begin
        next_nvm_data = reg_wdata;
      end else if (reg_select == DEAC_SEL_CONTROL) begin
        next_memory_select        = reg_wdata[DEAC_BIT_MEMSEL];
        next_configuration_select = reg_wdata[DEAC_BIT_CONFIG];
        next_row_erase            = reg_wdata[DEAC_BIT_ROW];
        next_write_error_flag     = reg_wdata[DEAC_BIT_ERROR];
        next_write_enable_gate    = reg_wdata[DEAC_BIT_GATE];
        // Gate must already be set from an earlier write
        if (reg_wdata[DEAC_BIT_WRITE] && write_enable_gate &&
            unlock == DEAC_UNLOCK_ARMED) begin
          next_write_start = 1'b1;
          launch           = 1'b1;
        end
        if (reg_wdata[DEAC_BIT_READ] &&
            !reg_wdata[DEAC_BIT_MEMSEL]) begin
          next_read_start = 1'b1;
        end
      end
    end

    // Cycle end: clear start and row-erase, raise completion
    if (timer_done) begin
      next_write_start         = 1'b0;
      next_row_erase           = 1'b0;
      next_write_error_flag    = 1'b0;
    end
    // Set wins over a same-cycle software clear
    if (write_complete_clear) begin
      next_write_complete_flag = 1'b0;
    end
    if (timer_done) begin
      next_write_complete_flag = 1'b1;
    end

    next_reg_rdata = DEAC_RESET_BYTE;
    if (reg_select == DEAC_SEL_CONTROL) begin
      next_reg_rdata = control_view(next_memory_select,
        next_configuration_select, next_row_erase, next_write_error_flag,
        next_write_enable_gate, next_write_start, next_read_start);
    end else if (reg_select == DEAC_SEL_DATA) begin
      next_reg_rdata = next_nvm_data;
    end else if (reg_select == DEAC_SEL_ADDRESS) begin
      next_reg_rdata = next_nvm_address;
    end
    if (!reg_read) begin
      next_reg_rdata = reg_rdata;
    end
  end

  // ==========================================================
  // Registers; reset kinds differ in what they keep
  always_ff @(posedge clock) begin
    if (sys_rst || power_on_reset) begin
      nvm_address          <= DEAC_RESET_BYTE;
      nvm_data             <= DEAC_RESET_BYTE;
      memory_select        <= 1'b0;
      configuration_select <= 1'b0;
      row_erase            <= 1'b0;
      write_error_flag     <= 1'b0;
      write_enable_gate    <= 1'b0;
      write_start          <= 1'b0;
      read_start           <= 1'b0;
      unlock               <= DEAC_UNLOCK_IDLE;
      write_complete_flag  <= 1'b0;
      reg_rdata            <= DEAC_RESET_BYTE;
    end else if (ext_reset) begin
      // Select and row-erase stay so firmware can trace the failure
      nvm_address          <= DEAC_RESET_BYTE;
      nvm_data             <= DEAC_RESET_BYTE;
      write_enable_gate    <= 1'b0;
      write_start          <= 1'b0;
      read_start           <= 1'b0;
      unlock               <= DEAC_UNLOCK_IDLE;
      reg_rdata            <= DEAC_RESET_BYTE;
      if (timer_busy) begin
        write_error_flag   <= 1'b1;
      end
    end else begin
      nvm_address          <= next_nvm_address;
      nvm_data             <= next_nvm_data;
      memory_select        <= next_memory_select;
      configuration_select <= next_configuration_select;
      row_erase            <= next_row_erase;
      write_error_flag     <= next_write_error_flag;
      write_enable_gate    <= next_write_enable_gate;
      write_start          <= next_write_start;
      read_start           <= next_read_start;
      unlock               <= next_unlock;
      write_complete_flag  <= next_write_complete_flag;
      reg_rdata            <= next_reg_rdata;
    end
  end

  assign write_busy = write_start;

  // ==========================================================
  // Array and self-timed cycle
  deac_memory #(
    .DEPTH (256)
  ) u_memory (
    .clock    (clock),
    .rd_addr  (nvm_address),
    .rd_data  (mem_rdata),
    .wr_pulse (mem_write),
    .wr_addr  (nvm_address),
    .wr_data  (nvm_data)
  );

  deac_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clock   (clock),
    .sys_rst (sys_rst || power_on_reset || ext_reset),
    .start   (launch),
    .busy    (timer_busy),
    .done    (timer_done)
  );

endmodule : deac_controller

// ===== deac_controller_asserts.sv
// Port assertions for the data memory access controller.
// Assumes binding onto deac_controller; sees only its ports.
`timescale 1ns/1ps

module deac_controller_asserts
  import deac_pkg::*;
#(
  parameter int WRITE_CYCLES = 5
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       power_on_reset,
  input wire logic       master_clear_reset,
  input wire logic       watchdog_timer_reset,
  input wire logic [1:0] reg_select,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       write_complete_clear,
  input wire logic       write_complete_flag,
  input wire logic       write_busy
);
  int bcnt;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst || power_on_reset);

  // ==========================================================
  // Busy length counter
  always_ff @(posedge clock) begin
    if (sys_rst || power_on_reset || !write_busy) begin
      bcnt <= 0;
    end else begin
      bcnt <= bcnt + 1;
    end
  end

  // ==========================================================
  // Properties
  // Busy stands exactly WRITE_CYCLES + 1 sampled edges per cycle
  AST_BUSY_MIN: assert property (
    write_busy && bcnt < WRITE_CYCLES && !master_clear_reset &&
    !watchdog_timer_reset |=> write_busy)
    else $error("write cycle ended early");
  AST_BUSY_MAX: assert property (
    write_busy |-> bcnt < WRITE_CYCLES + 1)
    else $error("write cycle too long");
  AST_START: assert property (
    $rose(write_busy) |-> $past(reg_write) &&
    $past(reg_select) == DEAC_SEL_CONTROL &&
    $past(reg_wdata[DEAC_BIT_WRITE]))
    else $error("write started without a start request");
  AST_DONE: assert property (
    $fell(write_busy) && !$past(master_clear_reset) &&
    !$past(watchdog_timer_reset) |-> write_complete_flag)
    else $error("completion flag not set");
  AST_STICKY: assert property (
    write_complete_flag && !write_complete_clear |=> write_complete_flag)
    else $error("completion flag dropped");
  AST_CLEAR: assert property (
    write_complete_clear && !write_busy |=> !write_complete_flag)
    else $error("completion flag not cleared");
  AST_UNLOCK: assert property (
    reg_read && reg_select == DEAC_SEL_UNLOCK |=> reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  AST_ABORT: assert property (
    master_clear_reset || watchdog_timer_reset |=> !write_busy)
    else $error("write not aborted");
  AST_POWER: assert property (
    disable iff (sys_rst) power_on_reset
    |=> !write_busy && !write_complete_flag && reg_rdata == 8'h00)
    else $error("power-up state wrong");

  cover property ($rose(write_busy));
  cover property ($rose(write_complete_flag));
  cover property (write_busy && master_clear_reset);
endmodule : deac_controller_asserts

bind deac_controller deac_controller_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .clock(clock), .sys_rst(sys_rst), .power_on_reset(power_on_reset),
  .master_clear_reset(master_clear_reset),
  .watchdog_timer_reset(watchdog_timer_reset),
  .reg_select(reg_select), .reg_write(reg_write), .reg_read(reg_read),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .write_complete_clear(write_complete_clear),
  .write_complete_flag(write_complete_flag), .write_busy(write_busy)
);

// ===== deac_cpu.sv
// CPU core model issuing register reads and writes.
// Assumes the bench compares read data against exp_q.
`timescale 1ns/1ps

module deac_cpu
  import deac_pkg::*;
(
  input  wire logic       clock,
  output logic      [1:0] reg_select,
  output logic            reg_write,
  output logic            reg_read,
  output logic      [7:0] reg_wdata,
  output logic            write_complete_clear
);
  logic [7:0] exp_q [$];

  initial begin
    reg_select = 2'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
    write_complete_clear = 1'b0;
  end

  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    @(posedge clock);
    reg_select <= s;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Released bus shows the inverse, never a stale copy
    reg_wdata <= ~v;
  endtask : wr

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    @(posedge clock);
    reg_select <= s;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
  endtask : rd

  task automatic go(input logic [7:0] c);
    wr(DEAC_SEL_UNLOCK, DEAC_KEY_FIRST);
    wr(DEAC_SEL_UNLOCK, DEAC_KEY_SECOND);
    wr(DEAC_SEL_CONTROL, c | 8'h02);
  endtask : go

  // Keeps the gate set so the next byte write can start at once;
  // the data register is read straight after the read start
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    wr(DEAC_SEL_ADDRESS, a);
    wr(DEAC_SEL_CONTROL, 8'h05);
    rd(DEAC_SEL_DATA, e);
  endtask : rdb

  task automatic clr;
    @(posedge clock);
    write_complete_clear <= 1'b1;
    @(posedge clock);
    write_complete_clear <= 1'b0;
  endtask : clr
endmodule : deac_cpu

// ===== tb_deac_controller.sv
// Self-checking bench for the data memory access controller.
// Assumes deac_cpu drives the register port.
`timescale 1ns/1ps

module tb_deac_controller;
  import deac_pkg::*;
  // Short write time keeps the run brief; still spans lock probes
  localparam int WC = 8;
  localparam logic [1:0] CT = DEAC_SEL_CONTROL;
  localparam logic [1:0] UL = DEAC_SEL_UNLOCK;
  localparam logic [1:0] DT = DEAC_SEL_DATA;
  localparam logic [1:0] AD = DEAC_SEL_ADDRESS;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        power_on_reset = 1'b0;
  logic        master_clear_reset = 1'b0;
  logic        watchdog_timer_reset = 1'b0;
  logic  [1:0] reg_select;
  logic        reg_write, reg_read, write_complete_clear;
  logic  [7:0] reg_wdata, reg_rdata, a, d;
  logic        write_complete_flag, write_busy;
  logic  [7:0] cv [3] = '{8'h44, 8'h84, 8'h9C};
  logic  [7:0] ev [3] = '{8'h44, 8'h84, 8'h84};
  logic [15:0] lf = 16'hE604;
  int          mismatches = 0;
  int          comparisons = 0;

  always #10 clock = ~clock;

  deac_controller #(.WRITE_CYCLES(WC)) deac_controller_inst (
    .clock(clock), .sys_rst(sys_rst), .power_on_reset(power_on_reset),
    .master_clear_reset(master_clear_reset),
    .watchdog_timer_reset(watchdog_timer_reset),
    .reg_select(reg_select), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .write_complete_clear(write_complete_clear),
    .write_complete_flag(write_complete_flag), .write_busy(write_busy));
  deac_cpu deac_cpu_inst (
    .clock(clock), .reg_select(reg_select), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata),
    .write_complete_clear(write_complete_clear));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic chk(input string n, input logic [7:0] s,
                     input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wrap_up;
    repeat (2) @(posedge clock);
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic wait_flag;
    int i;
    i = 0;
    while (write_complete_flag !== 1'b1 && i < 40) begin
      @(posedge clock);
      i++;
    end
    if (write_complete_flag !== 1'b1) begin
      mismatches++;
      wrap_up();
    end else begin
      chk("busy", {7'h0, write_busy}, 8'h00);
      deac_cpu_inst.clr();
      @(negedge clock);
      chk("flag", {7'h0, write_complete_flag}, 8'h00);
    end
  endtask : wait_flag

  // ==========================================================
  // Read result monitor
  always @(posedge clock) begin
    if (reg_read === 1'b1) begin
      #1;
      chk("rdata", reg_rdata, deac_cpu_inst.exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    deac_cpu_inst.rd(CT, 8'h00);
    deac_cpu_inst.wr(UL, 8'h5A);
    deac_cpu_inst.rd(UL, 8'h00);
    deac_cpu_inst.go(8'h00);
    // Busy rises at the start write's own edge: look half a cycle on
    @(negedge clock);
    chk("busy", {7'h0, write_busy}, 8'h00);
    deac_cpu_inst.go(8'h04);
    @(negedge clock);
    chk("busy", {7'h0, write_busy}, 8'h00);
    deac_cpu_inst.wr(UL, DEAC_KEY_FIRST);
    deac_cpu_inst.wr(DT, 8'h11);
    deac_cpu_inst.wr(UL, DEAC_KEY_SECOND);
    deac_cpu_inst.wr(CT, 8'h06);
    @(negedge clock);
    chk("busy", {7'h0, write_busy}, 8'h00);
    deac_cpu_inst.wr(UL, DEAC_KEY_SECOND);
    deac_cpu_inst.wr(UL, DEAC_KEY_FIRST);
    deac_cpu_inst.wr(CT, 8'h06);
    @(negedge clock);
    chk("busy", {7'h0, write_busy}, 8'h00);
    deac_cpu_inst.rd(CT, 8'h04);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lf[7:0];
      d = lf[15:8];
      lf = lfsr(lf);
      deac_cpu_inst.wr(AD, a);
      deac_cpu_inst.wr(DT, d);
      deac_cpu_inst.go(8'h04);
      @(negedge clock);
      chk("busy", {7'h0, write_busy}, 8'h01);
      deac_cpu_inst.wr(CT, 8'h00);
      deac_cpu_inst.wr(AD, ~a);
      deac_cpu_inst.wr(DT, ~d);
      wait_flag();
      deac_cpu_inst.rd(CT, 8'h04);
      deac_cpu_inst.rd(AD, a);
      deac_cpu_inst.rdb(a, d);
    end
    deac_cpu_inst.rd(DT, d);
    // A refused read must leave the firmware-written byte in place
    deac_cpu_inst.wr(DT, ~d);
    deac_cpu_inst.wr(CT, 8'h81);
    deac_cpu_inst.rd(CT, 8'h80);
    deac_cpu_inst.rd(DT, ~d);
    for (int k = 0; k < 3; k++) begin
      deac_cpu_inst.wr(DT, ~d);
      deac_cpu_inst.wr(CT, cv[k]);
      deac_cpu_inst.go(cv[k]);
      wait_flag();
      deac_cpu_inst.rd(CT, ev[k]);
      deac_cpu_inst.rdb(a, d);
    end
    for (int j = 0; j < 2; j++) begin
      deac_cpu_inst.wr(AD, 8'h3C);
      deac_cpu_inst.wr(DT, 8'hC3);
      deac_cpu_inst.wr(CT, 8'h94);
      deac_cpu_inst.go(8'h94);
      master_clear_reset <= (j == 0);
      watchdog_timer_reset <= (j == 1);
      @(posedge clock);
      master_clear_reset <= 1'b0;
      watchdog_timer_reset <= 1'b0;
      deac_cpu_inst.rd(CT, 8'h98);
      deac_cpu_inst.rd(AD, 8'h00);
      deac_cpu_inst.rd(DT, 8'h00);
    end
    deac_cpu_inst.wr(CT, 8'h04);
    power_on_reset <= 1'b1;
    @(posedge clock);
    power_on_reset <= 1'b0;
    deac_cpu_inst.rd(CT, 8'h00);
    wrap_up();
  end
endmodule : tb_deac_controller
